// [bpc_keypad.sv]
`timescale 1ns/1ps
// pins seen from outside: the port driver, an external source, or a weak pull-up
module bpc_keypad (
  // clock
  input  wire logic       clk,
  // port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  // external source, per bit
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_level
);
  logic [7:0] last_q;

  // an undriven pin flips every cycle so it never settles to a lucky value
  always_ff @(posedge clk) begin
    last_q <= pin_level;
  end

  // driver wins, else source, else pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_level[i] = pin_out[i];
      else if (ext_en[i]) pin_level[i] = ext_val[i];
      else if (pullup_en[i]) pin_level[i] = 1'b1;
      else pin_level[i] = ~last_q[i];
    end
  end
endmodule : bpc_keypad

// [bpc_pin_cell.sv]
`timescale 1ns/1ps
// one pin: driver, pull-up and change compare
module bpc_pin_cell #(
  parameter bit CAN_CHANGE = 1'b0
) (
  // pin side
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pullup_en,
  // control
  input  wire logic latch_bit,
  input  wire logic dir_bit,
  input  wire logic pullup_disable_n,
  input  wire logic snap_bit,
  output logic      mismatch
);
  always_comb begin
    pin_out   = latch_bit;
    pin_oe    = ~dir_bit;
    pullup_en = ~pullup_disable_n & dir_bit;
    mismatch  = CAN_CHANGE & dir_bit & (pin_in ^ snap_bit);
  end
endmodule : bpc_pin_cell

// [bpc_pkg.sv]
package bpc_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] ADDR_DATA      = 4'h0;
  localparam logic [3:0] ADDR_DIR       = 4'h1;
  localparam logic [3:0] ADDR_OPTION    = 4'h2;
  localparam logic [3:0] ADDR_INTCTL    = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'h5;
  localparam logic [3:0] ADDR_SLEEP     = 4'h6;
  // field positions
  localparam int         PULLUP_BIT     = 7;
  localparam int         CHANGE_FLAG_BIT = 0;
  localparam int         CHANGE_LO      = 4;
  // reset values
  localparam logic [7:0] DIR_RESET      = 8'hff;
  localparam logic [7:0] LATCH_RESET    = 8'h00;
  localparam logic [7:0] OPTION_RESET   = 8'h80;
  localparam logic [7:0] MASK_RESET     = 8'h00;
  // status bit positions
  localparam int         IRQ_CHANGE     = 0;
  localparam int         IRQ_WAKE       = 1;
  localparam int         IRQ_BITS       = 2;
  typedef enum logic {BPC_AWAKE, BPC_ASLEEP} bpc_power_type;
endpackage : bpc_pkg

// [bpc_port.sv]
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module bpc_port (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // pins
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pullup_en,
  // system
  output logic            irq,
  output logic            wake,
  output logic            asleep
);
  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] option_q;
  logic [7:0] snap_q;
  logic       flag_q;
  logic [bpc_pkg::IRQ_BITS-1:0] stat_q;
  logic [bpc_pkg::IRQ_BITS-1:0] mask_q;
  logic [7:0] rdata_q;
  logic [7:0] mism;
  logic       change;
  logic       port_acc;
  logic       rmw_byte_write;
  logic [7:0] rmw_d;
  bpc_pkg::bpc_power_type pwr_q;

  assign port_acc = (rd | wr) && (addr == bpc_pkg::ADDR_DATA);

  for (genvar i = 0; i < 8; i++) begin : g_pin
    bpc_pin_cell #(.CAN_CHANGE(i >= bpc_pkg::CHANGE_LO)) u_cell (
      .pin_in           (pin_in[i]),
      .pin_out          (pin_out[i]),
      .pin_oe           (pin_oe[i]),
      .pullup_en        (pullup_en[i]),
      .latch_bit        (latch_q[i]),
      .dir_bit          (dir_q[i]),
      .pullup_disable_n (option_q[bpc_pkg::PULLUP_BIT]),
      .snap_bit         (snap_q[i]),
      .mismatch         (mism[i])
    );
  end

  assign change = |mism;

  // rmw_byte_write is tied high, so a data write loads the whole wdata byte;
  // the sampled pins never reach the latch bits, not even on input pins
  assign rmw_byte_write = 1'b1;
  always_comb begin
    rmw_d = pin_in;
    if (rmw_byte_write) begin
      rmw_d = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      latch_q <= bpc_pkg::LATCH_RESET;
    end else if (wr && addr == bpc_pkg::ADDR_DATA) begin
      latch_q <= rmw_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dir_q <= bpc_pkg::DIR_RESET;
    end else if (wr && addr == bpc_pkg::ADDR_DIR) begin
      dir_q <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      option_q <= bpc_pkg::OPTION_RESET;
    end else if (wr && addr == bpc_pkg::ADDR_OPTION) begin
      option_q <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      snap_q <= 8'h00;
    end else if (port_acc) begin
      snap_q <= pin_in;
    end
  end

  // compare is blocked in the access cycle, a change there is lost
  // mismatch set wins over a software clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (change && !port_acc) begin
      flag_q <= 1'b1;
    end else if (wr && addr == bpc_pkg::ADDR_INTCTL) begin
      flag_q <= wdata[bpc_pkg::CHANGE_FLAG_BIT];
    end
  end

  // sticky status, cleared by reading; a new event in that cycle still sets
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stat_q <= '0;
    end else begin
      if (rd && addr == bpc_pkg::ADDR_IRQ_STAT) begin
        stat_q <= '0;
      end
      if (change && !port_acc) begin
        stat_q[bpc_pkg::IRQ_CHANGE] <= 1'b1;
      end
      if (pwr_q == bpc_pkg::BPC_ASLEEP && flag_q) begin
        stat_q[bpc_pkg::IRQ_WAKE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mask_q <= bpc_pkg::MASK_RESET[bpc_pkg::IRQ_BITS-1:0];
    end else if (wr && addr == bpc_pkg::ADDR_IRQ_MASK) begin
      mask_q <= wdata[bpc_pkg::IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwr_q <= bpc_pkg::BPC_AWAKE;
    end else begin
      case (pwr_q)
        bpc_pkg::BPC_AWAKE: begin
          if (wr && addr == bpc_pkg::ADDR_SLEEP && wdata[0]) begin
            pwr_q <= bpc_pkg::BPC_ASLEEP;
          end
        end
        bpc_pkg::BPC_ASLEEP: begin
          if (flag_q) begin
            pwr_q <= bpc_pkg::BPC_AWAKE;
          end
        end
        default: pwr_q <= bpc_pkg::BPC_AWAKE;
      endcase
    end
  end

  assign asleep = (pwr_q == bpc_pkg::BPC_ASLEEP);
  assign wake   = asleep & flag_q;
  assign irq    = |(stat_q & mask_q);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      if (addr == bpc_pkg::ADDR_DATA) begin
        rdata_q <= pin_in;
      end else if (addr == bpc_pkg::ADDR_DIR) begin
        rdata_q <= dir_q;
      end else if (addr == bpc_pkg::ADDR_OPTION) begin
        rdata_q <= option_q;
      end else if (addr == bpc_pkg::ADDR_INTCTL) begin
        rdata_q <= {7'h00, flag_q};
      end else if (addr == bpc_pkg::ADDR_IRQ_STAT) begin
        rdata_q <= {6'h00, stat_q};
      end else if (addr == bpc_pkg::ADDR_IRQ_MASK) begin
        rdata_q <= {6'h00, mask_q};
      end else if (addr == bpc_pkg::ADDR_SLEEP) begin
        rdata_q <= {7'h00, asleep};
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata = rdata_q;

  a_drive_dir: assert property (@(posedge clk) disable iff (!resetn)
    pin_oe == ~dir_q) else $error("pin enable not inverse of direction");
  // read data are the pins of the read cycle
  a_read_pins: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == bpc_pkg::ADDR_DATA |=> rdata == $past(pin_in))
    else $error("port read did not return pins");
  a_write_latch: assert property (@(posedge clk) disable iff (!resetn)
    wr && addr == bpc_pkg::ADDR_DATA |=> latch_q == $past(wdata) && pin_out == latch_q)
    else $error("latch not loaded by write");
  // pull-up follows control bit on inputs
  a_pullup_on: assert property (@(posedge clk) disable iff (!resetn)
    !option_q[bpc_pkg::PULLUP_BIT] |-> pullup_en == dir_q)
    else $error("pull-ups not enabled");
  a_pullup_out: assert property (@(posedge clk) disable iff (!resetn)
    (pullup_en & ~dir_q) == 8'h00) else $error("pull-up on output pin");
  a_pullup_reset: assert property (@(posedge clk)
    !resetn |=> pullup_en == 8'h00) else $error("pull-up on after reset");
  // lower pins never raise the flag
  a_low_ignored: assert property (@(posedge clk) disable iff (!resetn)
    mism[3:0] == 4'h0 && (mism[7:4] & ~dir_q[7:4]) == 4'h0)
    else $error("excluded pin in compare");
  // mismatch sets the flag next cycle
  a_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    change && !port_acc |=> flag_q) else $error("change flag not set");
  // sleeping with flag wakes in one cycle
  a_wake_up: assert property (@(posedge clk) disable iff (!resetn)
    asleep && flag_q |=> !asleep) else $error("no wake on change");
  // snapshot equals pins after an access
  a_snap_fresh: assert property (@(posedge clk) disable iff (!resetn)
    port_acc |=> snap_q == $past(pin_in)) else $error("snapshot not refreshed");
  // clear loses to a live mismatch
  a_clear_lost: assert property (@(posedge clk) disable iff (!resetn)
    wr && addr == bpc_pkg::ADDR_INTCTL && change && !port_acc |=> flag_q)
    else $error("flag cleared during mismatch");
  a_dir_reset: assert property (@(posedge clk)
    !resetn |=> dir_q == bpc_pkg::DIR_RESET && pin_oe == 8'h00)
    else $error("direction reset wrong");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
    !rd |=> rdata == 8'h00)
    else $error("read data not idle");
  a_latch_hold: assert property (@(posedge clk) disable iff (!resetn)
    !(wr && addr == bpc_pkg::ADDR_DATA) |=> $stable(latch_q))
    else $error("latch moved without write");
  a_dir_write: assert property (@(posedge clk) disable iff (!resetn)
    wr && addr == bpc_pkg::ADDR_DIR |=> dir_q == $past(wdata))
    else $error("direction not written");
  a_drive_value: assert property (@(posedge clk) disable iff (!resetn)
    pin_out == latch_q)
    else $error("pin driver not from latch");
  // control bit set keeps pull-ups off
  a_pullup_off: assert property (@(posedge clk) disable iff (!resetn)
    option_q[bpc_pkg::PULLUP_BIT] |-> pullup_en == 8'h00)
    else $error("pull-up on while disabled");
  a_access_blind: assert property (@(posedge clk) disable iff (!resetn)
    port_acc && !flag_q |=> !flag_q)
    else $error("flag set in access cycle");
  a_flag_hold: assert property (@(posedge clk) disable iff (!resetn)
    flag_q && !(wr && addr == bpc_pkg::ADDR_INTCTL) |=> flag_q)
    else $error("flag dropped without clear");
  // no flag without upper input change or an INTCTL write
  a_change_only: assert property (@(posedge clk) disable iff (!resetn)
    !change && !flag_q && !(wr && addr == bpc_pkg::ADDR_INTCTL) |=> !flag_q)
    else $error("flag set without change");
  a_irq_raise: assert property (@(posedge clk) disable iff (!resetn)
    change && !port_acc && mask_q[bpc_pkg::IRQ_CHANGE] |=> irq)
    else $error("irq not raised on change");
  a_wake_stat: assert property (@(posedge clk) disable iff (!resetn)
    asleep && flag_q |=> stat_q[bpc_pkg::IRQ_WAKE])
    else $error("wake not recorded");
  a_sleep_enter: assert property (@(posedge clk) disable iff (!resetn)
    wr && addr == bpc_pkg::ADDR_SLEEP && wdata[0] && !asleep |=> asleep)
    else $error("sleep not entered");
  a_snap_hold: assert property (@(posedge clk) disable iff (!resetn)
    !port_acc |=> $stable(snap_q))
    else $error("snapshot moved without access");
  a_stat_clear: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == bpc_pkg::ADDR_IRQ_STAT && !change && !(asleep && flag_q)
    |=> stat_q == '0)
    else $error("status not cleared by read");
endmodule : bpc_port

// [tb_bpc_port.sv]
`timescale 1ns/1ps
module tb_bpc_port;
  logic       clk, resetn, wr, rd, irq, wake, asleep;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, pin_level, pin_out, pin_oe, pullup_en, ext_val, ext_en, got;
  int         miscompares, checks;

  bpc_port i_bpc_port (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .irq(irq), .wake(wake), .asleep(asleep));
  bpc_keypad i_bpc_keypad (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_level));

  always #2.5 clk = ~clk;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask : rd_reg

  // lets a pin change or a write land before looking
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic wrap_up();
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    ext_val = 8'h00;
    ext_en = 8'hff;
    miscompares = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check("pin_oe", pin_oe, 8'h00);
    check("pullup_en", pullup_en, 8'h00);
    rd_reg(bpc_pkg::ADDR_DIR);
    check("dir", got, 8'hff);
    rd_reg(bpc_pkg::ADDR_OPTION);
    check("option", got, 8'h80);
    rd_reg(4'hf);
    check("unmapped", got, 8'h00);
    wr_reg(bpc_pkg::ADDR_DIR, 8'hf0);
    ext_val <= 8'ha0;
    wr_reg(bpc_pkg::ADDR_DATA, 8'h3c);
    settle();
    check("pin_oe", pin_oe, 8'h0f);
    check("pin_out", pin_out, 8'h3c);
    rd_reg(bpc_pkg::ADDR_DATA);
    check("data", got, 8'hac);
    // upper pins left to the pull-ups alone
    ext_en <= 8'h0f;
    wr_reg(bpc_pkg::ADDR_OPTION, 8'h00);
    settle();
    check("pullup_en", pullup_en, 8'hf0);
    rd_reg(bpc_pkg::ADDR_DATA);
    check("pulled", got, 8'hfc);
    ext_en <= 8'hff;
    wr_reg(bpc_pkg::ADDR_OPTION, 8'h80);
    settle();
    check("pullup_off", pullup_en, 8'h00);
    // pin 7 becomes an output so its source change must be ignored
    wr_reg(bpc_pkg::ADDR_DIR, 8'h7f);
    rd_reg(bpc_pkg::ADDR_DATA);
    wr_reg(bpc_pkg::ADDR_INTCTL, 8'h00);
    wr_reg(bpc_pkg::ADDR_IRQ_MASK, 8'h01);
    rd_reg(bpc_pkg::ADDR_IRQ_STAT);
    // no port polling while waiting for a change
    ext_val <= 8'h28;
    settle();
    rd_reg(bpc_pkg::ADDR_INTCTL);
    check("flag_low", got, 8'h00);
    ext_val <= 8'h08;
    settle();
    check("irq", {7'h00, irq}, 8'h01);
    rd_reg(bpc_pkg::ADDR_INTCTL);
    check("flag", got, 8'h01);
    wr_reg(bpc_pkg::ADDR_INTCTL, 8'h00);
    settle();
    rd_reg(bpc_pkg::ADDR_INTCTL);
    check("flag_kept", got, 8'h01);
    rd_reg(bpc_pkg::ADDR_DATA);
    wr_reg(bpc_pkg::ADDR_INTCTL, 8'h00);
    settle();
    rd_reg(bpc_pkg::ADDR_INTCTL);
    check("flag_clr", got, 8'h00);
    rd_reg(bpc_pkg::ADDR_IRQ_STAT);
    check("status", got, 8'h01);
    rd_reg(bpc_pkg::ADDR_IRQ_STAT);
    check("status_clr", got, 8'h00);
    check("irq_clr", {7'h00, irq}, 8'h00);
    wr_reg(bpc_pkg::ADDR_IRQ_MASK, 8'h00);
    ext_val <= 8'h18;
    settle();
    check("irq_mask", {7'h00, irq}, 8'h00);
    // end the mismatch and clear the flag, or sleep would end at once
    rd_reg(bpc_pkg::ADDR_DATA);
    wr_reg(bpc_pkg::ADDR_INTCTL, 8'h00);
    rd_reg(bpc_pkg::ADDR_IRQ_STAT);
    check("status_m", got, 8'h01);
    wr_reg(bpc_pkg::ADDR_SLEEP, 8'h01);
    settle();
    check("asleep", {7'h00, asleep}, 8'h01);
    ext_val <= 8'h58;
    got = 8'h00;
    for (int n = 0; n < 6 && got == 8'h00; n++) begin
      @(posedge clk);
      #1;
      got = {7'h00, wake};
    end
    check("wake", got, 8'h01);
    rd_reg(bpc_pkg::ADDR_IRQ_STAT);
    check("status_w", got, 8'h03);
    wrap_up();
  end

  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule : tb_bpc_port
